//--- rtl/scan_drive_pkg.sv
// Shared constants and types for the linear sensor scan drive block
package scan_drive_pkg;

  // ----------------------------------------------------------------------
  // Array geometry and sample format
  // ----------------------------------------------------------------------
  localparam int NUM_PIXELS = 128;
  localparam int ADDR_W = 7;
  localparam int LEVEL_W = 12;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 7'h7F;
  localparam logic [ADDR_W-1:0] FIRST_ADDR = 7'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 12'hFFF;
  localparam logic [LEVEL_W-1:0] LEVEL_CLEAR = 12'h000;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------------
  // Timing: figures in ns, cycle counts derived from the clock period
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int HIGH_MIN_NS = 200;
  localparam int CLEAR_MIN_NS = 5000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] HIGH_MIN_CYC =
    CNT_W'((HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // The clear pulse must be strictly longer than its figure
  localparam logic [CNT_W-1:0] CLEAR_MIN_CYC =
    CNT_W'(CLEAR_MIN_NS / CLK_PERIOD_NS + 1);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCAN_IDLE  = 2'b00,
    SCAN_ARMED = 2'b01,
    SCAN_RUN   = 2'b10,
    SCAN_END   = 2'b11
  } scan_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LEVEL_W-1:0] level;
  } pixel_sample_t;

  // Drive pins sampled together each clock
  typedef struct packed {
    logic phase1;
    logic phase2;
    logic start;
    logic video_reset;
    logic sat_gate;
  } drive_pins_t;

  localparam int PIN_W = 5;

endpackage : scan_drive_pkg

//--- rtl/pin_edge_detect.sv
// Rise and fall detection for a group of synchronous pin levels
`timescale 1ns/1ns
module pin_edge_detect #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] level_i,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] prev_q;

  // Previous level; reset to low so a pin already high reads as a rise
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      prev_q <= '0;
    else
      prev_q <= level_i;
  end

  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;

endmodule : pin_edge_detect

//--- rtl/sample_fifo.sv
// Sample FIFO with valid/ready on both sides and a registered output
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] cnt_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  wire push = in_valid_i && in_ready_o;
  wire load = (cnt_q != '0) && (!out_valid_q || out_ready_i);

  // Full is honest: the output stage adds one slot beyond DEPTH
  assign in_ready_o = (cnt_q != FULL_CNT);
  assign out_valid_o = out_valid_q;
  assign out_data_o = out_data_q;

  // Storage write
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data_i;
  end

  // Pointers and fill count
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (load)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      cnt_q <= cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(load);
    end
  end

  // Output register stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else if (load)
    begin
      out_valid_q <= 1'b1;
      out_data_q <= mem[rd_ptr_q];
    end
    else if (out_ready_i)
      out_valid_q <= 1'b0;
  end

endmodule : sample_fifo

//--- rtl/linear_sensor_scan_drive.sv
// Scan shift register, pixel charge model and readout of a linear array
`timescale 1ns/1ns
module linear_sensor_scan_drive (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic phase1_i,
  input wire logic phase2_i,
  input wire logic scan_start_pulse_i,
  input wire logic video_reset_i,
  input wire logic sat_gate_i,
  input wire logic [scan_drive_pkg::LEVEL_W-1:0] light_i,
  output scan_drive_pkg::pixel_sample_t pixel_o,
  output logic pixel_valid_o,
  input wire logic pixel_ready_i,
  output logic sample_room_o,
  output logic sample_lost_o,
  output logic scan_done_n_o,
  output logic scan_active_o,
  output logic video_at_bias_o,
  output logic drive_fault_o,
  output logic short_clear_o
);
  import scan_drive_pkg::*;

  // ----------------------------------------------------------------------
  // Saturating helpers
  // ----------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] cnt_step(
    input logic active,
    input logic [CNT_W-1:0] cnt
  );
    if (!active)
      cnt_step = CNT_ZERO;
    else if (cnt == CNT_MAX)
      cnt_step = cnt;
    else
      cnt_step = cnt + 1'b1;
  endfunction : cnt_step

  function automatic logic [LEVEL_W-1:0] level_add(
    input logic [LEVEL_W-1:0] level,
    input logic [LEVEL_W-1:0] inc
  );
    logic [LEVEL_W:0] sum;
    sum = {1'b0, level} + {1'b0, inc};
    if (sum[LEVEL_W])
      level_add = LEVEL_MAX;
    else
      level_add = sum[LEVEL_W-1:0];
  endfunction : level_add

  // ----------------------------------------------------------------------
  // Pin sampling and edges
  // ----------------------------------------------------------------------
  drive_pins_t pins;
  drive_pins_t pins_rise;
  drive_pins_t pins_fall;

  assign pins.phase1 = phase1_i;
  assign pins.phase2 = phase2_i;
  assign pins.start = scan_start_pulse_i;
  assign pins.video_reset = video_reset_i;
  assign pins.sat_gate = sat_gate_i;

  pin_edge_detect #(
    .W(PIN_W)
  ) u_edges (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(pins),
    .rise_o(pins_rise),
    .fall_o(pins_fall)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  scan_state_t state_q;
  scan_state_t state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic scan_done_n_q;
  logic scan_done_n_d;
  logic [LEVEL_W-1:0] charge_q [NUM_PIXELS];
  logic [CNT_W-1:0] ph1_cnt_q;
  logic [CNT_W-1:0] ph2_cnt_q;
  logic [CNT_W-1:0] start_cnt_q;
  logic [CNT_W-1:0] overlap_cnt_q;
  logic [CNT_W-1:0] clear_cnt_q;
  logic video_at_bias_q;
  logic drive_fault_q;
  logic short_clear_q;
  logic sample_lost_q;
  logic sample_room_q;
  logic scan_active_q;

  // ----------------------------------------------------------------------
  // Scan sequencing decode
  // ----------------------------------------------------------------------
  wire ph2_rise = pins_rise.phase2;
  wire ph2_fall = pins_fall.phase2;
  wire in_run = (state_q == SCAN_RUN);
  // A pixel is read at every phase two rise while the token walks
  wire read_pixel = in_run && ph2_rise;
  wire last_pixel = (addr_q == LAST_ADDR);
  wire fifo_ready;
  pixel_sample_t sample;

  assign sample.addr = addr_q;
  assign sample.level = charge_q[addr_q];

  // Drive checks: a driver that breaks its timing gets a sticky flag,
  // since the array itself would silently misbehave
  wire both_high = phase1_i && phase2_i;
  wire ph1_short = pins_fall.phase1 && (ph1_cnt_q < HIGH_MIN_CYC);
  wire ph2_short = ph2_fall && (ph2_cnt_q < HIGH_MIN_CYC);
  wire start_short = pins_fall.start &&
    ((start_cnt_q < HIGH_MIN_CYC) || (overlap_cnt_q < HIGH_MIN_CYC));
  // A second phase two fall under one start pulse breaks the load
  wire double_load = (state_q == SCAN_RUN) && scan_start_pulse_i &&
    ph2_fall;
  wire no_load = (state_q == SCAN_ARMED) && pins_fall.start;
  // Start during a running scan would cut it short
  wire early_start = (state_q == SCAN_RUN) && pins_rise.start &&
    !ph2_fall;
  wire reset_misaligned =
    (pins_rise.video_reset && !phase2_i) ||
    (pins_fall.video_reset && phase2_i);
  wire fault_now = both_high || ph1_short || ph2_short || start_short ||
    double_load || no_load || early_start || reset_misaligned;
  // Gap between phases is only checked at clock resolution: with 50 ns
  // sampling an overlap is the only slow-edge symptom visible here
  wire clear_short = pins_fall.sat_gate &&
    (clear_cnt_q < CLEAR_MIN_CYC);

  // ----------------------------------------------------------------------
  // Scan state machine, next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    scan_done_n_d = scan_done_n_q;
    unique case (state_q)
      SCAN_IDLE:
      begin
        if (scan_start_pulse_i)
          state_d = SCAN_ARMED;
      end
      SCAN_ARMED:
      begin
        // The phase two fall under start loads the token at pixel 0
        if (ph2_fall && scan_start_pulse_i)
        begin
          state_d = SCAN_RUN;
          addr_d = FIRST_ADDR;
        end
        else if (!scan_start_pulse_i)
          state_d = SCAN_IDLE;
      end
      SCAN_RUN:
      begin
        if (double_load)
        begin
          state_d = SCAN_ARMED;
          addr_d = FIRST_ADDR;
        end
        else if (read_pixel)
        begin
          if (last_pixel)
          begin
            state_d = SCAN_END;
            scan_done_n_d = 1'b0;
          end
          else
            addr_d = addr_q + 1'b1;
        end
      end
      SCAN_END:
      begin
        // End-of-scan lasts one phase two period
        if (ph2_rise)
        begin
          scan_done_n_d = 1'b1;
          state_d = scan_start_pulse_i ? SCAN_ARMED : SCAN_IDLE;
        end
      end
    endcase
  end

  // Scan state registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SCAN_IDLE;
      addr_q <= FIRST_ADDR;
      scan_done_n_q <= 1'b1;
      scan_active_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      scan_done_n_q <= scan_done_n_d;
      scan_active_q <= (state_d == SCAN_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // Pixel charge: gate clear beats readout clear beats accumulation
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < NUM_PIXELS; i++)
    begin
      if (!rst_n_i || sat_gate_i)
        charge_q[i] <= LEVEL_CLEAR;
      else if (read_pixel && (addr_q == ADDR_W'(i)))
        charge_q[i] <= LEVEL_CLEAR;
      else
        charge_q[i] <= level_add(charge_q[i], light_i);
    end
  end

  // ----------------------------------------------------------------------
  // Pulse width counters
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ph1_cnt_q <= CNT_ZERO;
      ph2_cnt_q <= CNT_ZERO;
      start_cnt_q <= CNT_ZERO;
      overlap_cnt_q <= CNT_ZERO;
      clear_cnt_q <= CNT_ZERO;
    end
    else
    begin
      ph1_cnt_q <= cnt_step(phase1_i, ph1_cnt_q);
      ph2_cnt_q <= cnt_step(phase2_i, ph2_cnt_q);
      start_cnt_q <= cnt_step(scan_start_pulse_i, start_cnt_q);
      // Overlap accumulates over the whole start pulse
      overlap_cnt_q <= scan_start_pulse_i ?
        cnt_step(1'b1, overlap_cnt_q) - CNT_W'(!phase2_i) : CNT_ZERO;
      clear_cnt_q <= cnt_step(sat_gate_i, clear_cnt_q);
    end
  end

  // ----------------------------------------------------------------------
  // Video line, sticky status and buffer room flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      video_at_bias_q <= 1'b0;
      drive_fault_q <= 1'b0;
      short_clear_q <= 1'b0;
      sample_lost_q <= 1'b0;
      sample_room_q <= 1'b0;
    end
    else
    begin
      video_at_bias_q <= video_reset_i;
      drive_fault_q <= drive_fault_q || fault_now;
      short_clear_q <= short_clear_q || clear_short;
      // The array cannot be stalled, so a full buffer loses the sample
      sample_lost_q <= sample_lost_q || (read_pixel && !fifo_ready);
      sample_room_q <= fifo_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------------
  sample_fifo #(
    .WIDTH($bits(pixel_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(read_pixel),
    .in_ready_o(fifo_ready),
    .in_data_i(sample),
    .out_valid_o(pixel_valid_o),
    .out_ready_i(pixel_ready_i),
    .out_data_o(pixel_o)
  );

  assign scan_done_n_o = scan_done_n_q;
  assign scan_active_o = scan_active_q;
  assign video_at_bias_o = video_at_bias_q;
  assign drive_fault_o = drive_fault_q;
  assign short_clear_o = short_clear_q;
  assign sample_lost_o = sample_lost_q;
  assign sample_room_o = sample_room_q;

endmodule : linear_sensor_scan_drive

//--- verif/scan_timing_gen.sv
// Timing generator model that drives the scan pins of the sensor block
`timescale 1ns/1ns
module scan_timing_gen (
  input wire logic clk_i,
  output logic phase1_o,
  output logic phase2_o,
  output logic start_o,
  output logic video_reset_o,
  output logic sat_gate_o
);
  // ------------------------------------------------------------
  // Pin sequences, all changed just after a falling clock edge
  // ------------------------------------------------------------
  initial
  begin
    {phase1_o, phase2_o, start_o, video_reset_o, sat_gate_o} = 5'h00;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n
  // One frame of n pixels; h is each phase's high time in clocks
  task automatic scan(input int h, input int n);
    start_o = 1'b1;
    phase2_o = 1'b1;
    wait_n(h);
    phase2_o = 1'b0;
    wait_n(2);
    start_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      phase1_o = 1'b1;
      wait_n(h);
      phase1_o = 1'b0;
      wait_n(1);
      phase2_o = 1'b1;
      wait_n(1);
      video_reset_o = 1'b1;
      wait_n(h - 1);
      phase2_o = 1'b0;
      wait_n(1);
      video_reset_o = 1'b0;
      wait_n(1);
    end
  endtask : scan
  // Deliberate fault: both phases high together
  task automatic overlap();
    {phase1_o, phase2_o} = 2'h3;
    wait_n(4);
    {phase1_o, phase2_o} = 2'h0;
    wait_n(3);
  endtask : overlap
  // Deliberate fault: start pulse with no phase two fall under it
  task automatic lone_start(input int n);
    start_o = 1'b1;
    wait_n(n);
    start_o = 1'b0;
    wait_n(3);
  endtask : lone_start
  // Deliberate fault: video reset raised while phase two is low
  task automatic stray_reset();
    video_reset_o = 1'b1;
    wait_n(2);
    video_reset_o = 1'b0;
    wait_n(3);
  endtask : stray_reset
  // Global clear pulse of n clocks
  task automatic clear(input int n);
    sat_gate_o = 1'b1;
    wait_n(n);
    sat_gate_o = 1'b0;
    wait_n(3);
  endtask : clear
endmodule : scan_timing_gen

//--- verif/scan_drive_sva.sv
// Port-level assertions for the linear sensor scan drive block
`timescale 1ns/1ns
module scan_drive_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic phase1_i,
  input wire logic phase2_i,
  input wire logic scan_start_pulse_i,
  input wire logic video_reset_i,
  input wire logic sat_gate_i,
  input wire scan_drive_pkg::pixel_sample_t pixel_o,
  input wire logic pixel_valid_o,
  input wire logic pixel_ready_i,
  input wire logic sample_room_o,
  input wire logic scan_done_n_o,
  input wire logic scan_active_o,
  input wire logic video_at_bias_o,
  input wire logic drive_fault_o,
  input wire logic short_clear_o
);
  import scan_drive_pkg::*;
  // ------------------------------------------------------------
  // Gate pulse length, saturating so a held gate never wraps
  // ------------------------------------------------------------
  logic [7:0] gate_len_q;
  logic [7:0] gate_len_d;
  assign gate_len_d = (gate_len_q == 8'hFF) ? 8'hFF : gate_len_q + 8'h01;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !sat_gate_i)
      gate_len_q <= 8'h00;
    else
      gate_len_q <= gate_len_d;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Phase two falls while start is high and no scan runs
  sequence arm_s;
    scan_start_pulse_i && $fell(phase2_i) && !scan_active_o;
  endsequence
  // End of frame pending when the next phase two rise comes
  sequence end_s;
    !scan_done_n_o && $rose(phase2_i);
  endsequence
  scan_arm_a: assert property (arm_s |=> scan_active_o)
    else $error("scan did not start");
  arm_cause_a: assert property ($rose(scan_active_o) |->
    $past(scan_start_pulse_i)) else $error("scan began without start");
  done_end_a: assert property (end_s |=> scan_done_n_o)
    else $error("end of scan too long");
  done_cause_a: assert property ($fell(scan_done_n_o) |->
    !scan_active_o && $past(scan_active_o)) else $error("stray end");
  read_push_a: assert property ($rose(phase2_i) && scan_active_o &&
    sample_room_o |-> ##[0:2] pixel_valid_o) else $error("no sample");
  valid_hold_a: assert property (pixel_valid_o && !pixel_ready_i |=>
    pixel_valid_o && $stable(pixel_o)) else $error("sample dropped");
  bias_rise_a: assert property ($rose(video_reset_i) |=>
    video_at_bias_o) else $error("line not at bias");
  bias_fall_a: assert property ($fell(video_reset_i) |=>
    !video_at_bias_o) else $error("line held at bias");
  overlap_flag_a: assert property (phase1_i && phase2_i |->
    ##[1:2] drive_fault_o) else $error("overlap not flagged");
  reset_fault_a: assert property ($rose(video_reset_i) && !phase2_i |->
    ##[1:2] drive_fault_o) else $error("stray reset not flagged");
  clear_short_a: assert property ($fell(sat_gate_i) &&
    gate_len_q < CLEAR_MIN_CYC |-> ##[1:2] short_clear_o) else $error("short");
  clear_long_a: assert property ($fell(sat_gate_i) &&
    gate_len_q >= CLEAR_MIN_CYC && !short_clear_o |-> ##1 !short_clear_o ##1
    !short_clear_o) else $error("long clear flagged");
endmodule : scan_drive_sva
bind linear_sensor_scan_drive scan_drive_sva chk (.clk_i, .rst_n_i,
  .phase1_i, .phase2_i, .scan_start_pulse_i, .video_reset_i, .sat_gate_i,
  .pixel_o, .pixel_valid_o, .pixel_ready_i, .sample_room_o, .scan_done_n_o,
  .scan_active_o, .video_at_bias_o, .drive_fault_o, .short_clear_o);

//--- verif/linear_sensor_scan_drive_tb.sv
// Self-checking bench of the linear sensor scan drive block
`timescale 1ns/1ns
module linear_sensor_scan_drive_tb;
  import scan_drive_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic phase1_i, phase2_i, scan_start_pulse_i, video_reset_i, sat_gate_i;
  logic [LEVEL_W-1:0] light_i;
  pixel_sample_t pixel_o;
  logic pixel_valid_o, sample_room_o, sample_lost_o, scan_done_n_o;
  logic scan_active_o, video_at_bias_o, drive_fault_o, short_clear_o;
  logic pixel_ready_i = 1'b0;
  bit stall = 1'b0;
  int mismatches, check_count, cycles;
  int seed = 32'h18d9_74ce;
  // Idle clocks after each frame so the consumer can drain the buffer
  localparam int SETTLE = 30;
  pixel_sample_t got_q[$];
  linear_sensor_scan_drive DUT (.clk_i, .rst_n_i, .phase1_i, .phase2_i,
    .scan_start_pulse_i, .video_reset_i, .sat_gate_i, .light_i, .pixel_o,
    .pixel_valid_o, .pixel_ready_i, .sample_room_o, .sample_lost_o,
    .scan_done_n_o, .scan_active_o, .video_at_bias_o, .drive_fault_o,
    .short_clear_o);
  scan_timing_gen gen (.clk_i, .phase1_o(phase1_i), .phase2_o(phase2_i),
    .start_o(scan_start_pulse_i), .video_reset_o(video_reset_i),
    .sat_gate_o(sat_gate_i));
  // ------------------------------------------------------------
  // Clock, random consumer, sample capture and hang limit
  // ------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(negedge clk_i) pixel_ready_i <= !stall && ($random(seed) & 1);
  always @(posedge clk_i)
  begin
    if (pixel_valid_o === 1'b1 && pixel_ready_i === 1'b1)
      got_q.push_back(pixel_o);
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Words a stalled consumer finds: buffer plus output slot
  function automatic int kept(input int n);
    return (n > FIFO_DEPTH + 1) ? FIFO_DEPTH + 1 : n;
  endfunction : kept
  // Clocks from one frame's start to the next: load, pixels, settle
  function automatic int frame_cyc(input int h, input int n);
    return h + 2 + n * (2 * h + 3) + SETTLE;
  endfunction : frame_cyc
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check(32'({drive_fault_o, short_clear_o, sample_lost_o,
      scan_done_n_o, pixel_valid_o}), 32'h2);
  endtask : do_reset
  task automatic frame(input int h, input int n);
    got_q.delete();
    gen.scan(h, n);
    repeat (SETTLE) @(negedge clk_i);
  endtask : frame
  // Mode 0 dark, 1 ascending after clear, 2 flat, 3 addresses only
  task automatic check_frame(input int n, input int mode);
    int flat;
    // A pixel read each frame holds one frame period of light, less
    // the clock on which the read itself cleared it
    flat = int'(light_i) * (frame_cyc(4, n) - 1);
    check(32'(got_q.size()), 32'(n));
    foreach (got_q[i])
    begin
      check(32'(got_q[i].addr), 32'(i));
      if (mode == 0)
        check(32'(got_q[i].level), 32'(LEVEL_CLEAR));
      if (mode == 1 && i > 0)
        check(32'(got_q[i].level > got_q[i-1].level), 32'h1);
      if (mode == 2)
        check(32'(got_q[i].level), 32'(flat));
    end
  endtask : check_frame
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  initial
  begin
    rst_n_i = 1'b0;
    light_i = 12'h000;
    do_reset();
    // Dark frame after a global clear
    gen.clear(120);
    frame(4, NUM_PIXELS);
    check_frame(NUM_PIXELS, 0);
    check(32'(scan_done_n_o), 32'h0);
    check(32'(short_clear_o | drive_fault_o), 32'h0);
    // Lit frames back to back; light kept low so nothing saturates
    light_i = LEVEL_W'(1 + ($random(seed) & 1));
    gen.clear(120);
    frame(4, NUM_PIXELS);
    check_frame(NUM_PIXELS, 1);
    frame(4, NUM_PIXELS);
    check_frame(NUM_PIXELS, 2);
    // Stalled consumer: buffer fills, refuses, then drains
    stall = 1'b1;
    frame(4, 20);
    check(32'(sample_room_o), 32'h0);
    check(32'(sample_lost_o), 32'(20 > kept(20)));
    stall = 1'b0;
    repeat (100) @(negedge clk_i);
    check_frame(kept(20), 3);
    check(32'(sample_room_o), 32'h1);
    // Driver faults, each cleared by a fresh reset
    do_reset();
    gen.overlap();
    check(32'(drive_fault_o), 32'h1);
    do_reset();
    frame(2, 3);
    check(32'(drive_fault_o), 32'h1);
    do_reset();
    gen.lone_start(6);
    check(32'(drive_fault_o), 32'h1);
    check(32'(scan_active_o), 32'h0);
    do_reset();
    gen.stray_reset();
    check(32'(drive_fault_o), 32'h1);
    do_reset();
    gen.clear(50);
    check(32'(short_clear_o), 32'h1);
    test_done();
  end
endmodule : linear_sensor_scan_drive_tb
